//--- hdl/fpi_irq_autovector.sv
// Shared FIFO and waveform interrupt: requests, main flag and autovector fetch
`timescale 1ns/1ps
module fpi_irq_autovector (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        resetn,
  input  wire logic                        clk_en,
  // Register port
  input  wire fpi_pkg::fpi_bus_type        bus,
  output logic      [fpi_pkg::DATA_W-1:0]  rd_data,
  // Source events, one-cycle pulses
  input  wire fpi_pkg::fpi_src_type        src_event,
  // CPU program fetch
  input  wire fpi_pkg::fpi_fetch_type      fetch,
  output logic      [7:0]                  fetch_data,
  // Interrupt outputs
  output logic                             fifo_port_shared_irq,
  output logic                             irq_pending,
  output logic      [7:0]                  fifo_irq_vector_code
);

  logic [fpi_pkg::NUM_SRC-1:0] source_enable_bit;
  logic [fpi_pkg::NUM_SRC-1:0] request;
  logic [fpi_pkg::NUM_SRC-1:0] next_request;
  logic [fpi_pkg::NUM_SRC-1:0] events;
  logic [fpi_pkg::NUM_SRC-1:0] w1c;
  logic [fpi_pkg::NUM_SRC-1:0] active;
  logic                        fifo_autovector_enable;
  logic                        any_active;
  logic                        any_active_q;
  logic                        cleared_q;
  logic                        main_set;
  logic                        main_clr;
  logic                        wr_enable;
  logic                        wr_request;
  logic                        wr_setup;
  logic                        wr_ext;
  logic                        av_hit;

  assign events = src_event;

  // Write decode
  assign wr_enable  = bus.wr && (bus.addr == fpi_pkg::OFS_ENABLE);
  assign wr_request = bus.wr && (bus.addr == fpi_pkg::OFS_REQUEST);
  assign wr_setup   = bus.wr && (bus.addr == fpi_pkg::OFS_SETUP);
  assign wr_ext     = bus.wr && (bus.addr == fpi_pkg::OFS_EXT_FLAG);

  // Write-one-to-clear; a new event in the same cycle wins
  assign w1c          = wr_request ? bus.wdata[fpi_pkg::NUM_SRC-1:0] : '0;
  assign next_request = (request & ~w1c) | events;

  // Only enabled, requested sources compete
  assign active      = request & source_enable_bit;
  assign any_active  = |active;
  assign irq_pending = any_active;

  // Source enables, written by firmware
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      source_enable_bit <= fpi_pkg::ENABLE_RESET;
    end else if (clk_en && wr_enable) begin
      source_enable_bit <= bus.wdata[fpi_pkg::NUM_SRC-1:0];
    end
  end

  // Individual request latches
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      request <= fpi_pkg::REQUEST_RESET;
    end else if (clk_en) begin
      request <= next_request;
    end
  end

  // Setup register, autovector enable
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fifo_autovector_enable <= 1'b0;
    end else if (clk_en && wr_setup) begin
      fifo_autovector_enable <= bus.wdata[fpi_pkg::SETUP_AUTOVEC_BIT];
    end
  end

  // History for edge and re-trigger detection
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      any_active_q <= 1'b0;
      cleared_q    <= 1'b0;
    end else if (clk_en) begin
      any_active_q <= any_active;
      cleared_q    <= |(w1c & request);
    end
  end

  // A pending source re-raises the main flag after any individual clear;
  // if the flag is still set then, the re-raise is absorbed and lost
  assign main_set = any_active && (!any_active_q || cleared_q);
  assign main_clr = wr_ext && !bus.wdata[fpi_pkg::EXT_MAIN_BIT];

  // Main shared flag, set wins over clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fifo_port_shared_irq <= 1'b0;
    end else if (clk_en) begin
      if (main_set) begin
        fifo_port_shared_irq <= 1'b1;
      end else if (main_clr) begin
        fifo_port_shared_irq <= 1'b0;
      end
    end
  end

  // Priority pick into the vector register
  fpi_vector_pick u_pick (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .active  (active),
    .vector  (fifo_irq_vector_code)
  );

  // Low address byte of the jump at entry is the autovector slot
  assign av_hit = fetch.valid && fifo_autovector_enable &&
                  (fetch.addr == fpi_pkg::AUTOVEC_ADDR);

  // Fetch path, same latency as memory so the jump costs no extra cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fetch_data <= 8'h00;
    end else if (clk_en && fetch.valid) begin
      fetch_data <= av_hit ? fifo_irq_vector_code : fetch.mem_data;
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 16'h0000;
    end else if (clk_en) begin
      if (!bus.rd) begin
        rd_data <= 16'h0000;
      end else if (bus.addr == fpi_pkg::OFS_ENABLE) begin
        rd_data <= {2'b00, source_enable_bit};
      end else if (bus.addr == fpi_pkg::OFS_REQUEST) begin
        rd_data <= {2'b00, request};
      end else if (bus.addr == fpi_pkg::OFS_VECTOR) begin
        rd_data <= {8'h00, fifo_irq_vector_code};
      end else if (bus.addr == fpi_pkg::OFS_SETUP) begin
        rd_data <= {15'h0000, fifo_autovector_enable};
      end else if (bus.addr == fpi_pkg::OFS_EXT_FLAG) begin
        rd_data <= {9'h000, fifo_port_shared_irq, 6'h00};
      end else begin
        rd_data <= 16'h0000;
      end
    end
  end

  // Checks on the design's own registers and outputs
  sequence s_av_fetch;
    clk_en && av_hit;
  endsequence

  sequence s_clear_with_pending;
    clk_en && (|(w1c & request)) && !(|events) ##1
      clk_en && any_active && !main_clr;
  endsequence

  property p_vec_pf;
    @(posedge sys_clk) disable iff (!resetn)
      clk_en && active[0] |=> fifo_irq_vector_code == 8'h80;
  endproperty
  a_vec_pf: assert property (p_vec_pf) else $error("ep2 programmable code wrong");

  property p_vec_ef;
    @(posedge sys_clk) disable iff (!resetn)
      clk_en && active[4] && (active[3:0] == 4'h0) |=> fifo_irq_vector_code == 8'h90;
  endproperty
  a_vec_ef: assert property (p_vec_ef) else $error("ep2 empty code wrong");

  property p_vec_ff;
    @(posedge sys_clk) disable iff (!resetn)
      clk_en && active[11] && (active[10:0] == 11'h000) |=> fifo_irq_vector_code == 8'hAC;
  endproperty
  a_vec_ff: assert property (p_vec_ff) else $error("ep8 full code wrong");

  property p_vec_wave;
    @(posedge sys_clk) disable iff (!resetn)
      clk_en && (active == 14'h2000) |=> fifo_irq_vector_code == 8'hB4;
  endproperty
  a_vec_wave: assert property (p_vec_wave) else $error("waveform event code wrong");

  property p_vec_form;
    @(posedge sys_clk) disable iff (!resetn)
      fifo_irq_vector_code[7] && (fifo_irq_vector_code[1:0] == 2'b00);
  endproperty
  a_vec_form: assert property (p_vec_form) else $error("vector code malformed");

  property p_av_fetch;
    @(posedge sys_clk) disable iff (!resetn)
      s_av_fetch |=> fetch_data == $past(fifo_irq_vector_code);
  endproperty
  a_av_fetch: assert property (p_av_fetch) else $error("autovector not substituted");

  property p_w1c;
    @(posedge sys_clk) disable iff (!resetn)
      clk_en && wr_request && bus.wdata[0] && !events[0] |=> !request[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("request not cleared by one");

  property p_main_clr;
    @(posedge sys_clk) disable iff (!resetn)
      clk_en && main_clr && !main_set |=> !fifo_port_shared_irq;
  endproperty
  a_main_clr: assert property (p_main_clr) else $error("main flag not cleared");

  property p_retrigger;
    @(posedge sys_clk) disable iff (!resetn)
      s_clear_with_pending |=> fifo_port_shared_irq;
  endproperty
  a_retrigger: assert property (p_retrigger) else $error("pending source not re-raised");

  property p_main_cause;
    @(posedge sys_clk) disable iff (!resetn)
      $rose(fifo_port_shared_irq) |-> $past(any_active);
  endproperty
  a_main_cause: assert property (p_main_cause) else $error("main flag without source");

  // Frozen clock enable holds every register, outputs included
  property p_freeze;
    @(posedge sys_clk) disable iff (!resetn)
      !clk_en |=> $stable(request) && $stable(source_enable_bit) &&
                  $stable(fifo_autovector_enable) && $stable(fifo_port_shared_irq) &&
                  $stable(fifo_irq_vector_code) && $stable(rd_data) && $stable(fetch_data);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  property p_masked;
    @(posedge sys_clk) disable iff (!resetn)
      clk_en && !any_active && !fifo_port_shared_irq |=> !fifo_port_shared_irq;
  endproperty
  a_masked: assert property (p_masked) else $error("main flag without enabled source");

  property p_main_rise;
    @(posedge sys_clk) disable iff (!resetn)
      clk_en && $rose(any_active) |=> fifo_port_shared_irq;
  endproperty
  a_main_rise: assert property (p_main_rise) else $error("first source did not raise main");

  property p_vec_hold;
    @(posedge sys_clk) disable iff (!resetn)
      clk_en && !any_active |=> $stable(fifo_irq_vector_code);
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("idle vector moved");

  property p_enable_wr;
    @(posedge sys_clk) disable iff (!resetn)
      clk_en && wr_enable |=> source_enable_bit == $past(bus.wdata[fpi_pkg::NUM_SRC-1:0]);
  endproperty
  a_enable_wr: assert property (p_enable_wr) else $error("enable write lost");

  property p_setup;
    @(posedge sys_clk) disable iff (!resetn)
      clk_en && wr_setup |=> fifo_autovector_enable == $past(bus.wdata[fpi_pkg::SETUP_AUTOVEC_BIT]);
  endproperty
  a_setup: assert property (p_setup) else $error("autovector enable write lost");

  property p_fetch_mem;
    @(posedge sys_clk) disable iff (!resetn)
      clk_en && fetch.valid && !av_hit |=> fetch_data == $past(fetch.mem_data);
  endproperty
  a_fetch_mem: assert property (p_fetch_mem) else $error("memory byte not passed");

  property p_rd_vector;
    @(posedge sys_clk) disable iff (!resetn)
      clk_en && bus.rd && (bus.addr == fpi_pkg::OFS_VECTOR) |=>
        rd_data == {8'h00, $past(fifo_irq_vector_code)};
  endproperty
  a_rd_vector: assert property (p_rd_vector) else $error("vector read wrong");

  property p_rd_request;
    @(posedge sys_clk) disable iff (!resetn)
      clk_en && bus.rd && (bus.addr == fpi_pkg::OFS_REQUEST) |=>
        rd_data == {2'b00, $past(request)};
  endproperty
  a_rd_request: assert property (p_rd_request) else $error("request read wrong");

  // Per source: own code when leading, set by its event, kept unless cleared
  for (genvar s = 0; s < fpi_pkg::NUM_SRC; s++) begin : g_src_chk
    localparam logic [fpi_pkg::NUM_SRC-1:0] ONE_HOT = {{(fpi_pkg::NUM_SRC-1){1'b0}}, 1'b1} << s;
    localparam logic [fpi_pkg::NUM_SRC-1:0] HIGHER  = ONE_HOT - 1'b1;
    localparam logic [7:0]                  CODE    = fpi_pkg::VEC_BASE + 8'(4 * s);

    property p_vec_each;
      @(posedge sys_clk) disable iff (!resetn)
        clk_en && active[s] && ((active & HIGHER) == '0) |=> fifo_irq_vector_code == CODE;
    endproperty
    a_vec_each: assert property (p_vec_each) else $error("leading source code wrong");

    property p_req_set;
      @(posedge sys_clk) disable iff (!resetn)
        clk_en && events[s] |=> request[s];
    endproperty
    a_req_set: assert property (p_req_set) else $error("request not set by event");

    property p_req_keep;
      @(posedge sys_clk) disable iff (!resetn)
        clk_en && !events[s] && !w1c[s] |=> $stable(request[s]);
    endproperty
    a_req_keep: assert property (p_req_keep) else $error("request changed without cause");
  end

endmodule

//--- include/fpi_pkg.sv
// Constants and types for the shared FIFO and waveform interrupt with autovector
package fpi_pkg;

  // Sizes
  localparam int ADDR_W  = 4;
  localparam int DATA_W  = 16;
  localparam int NUM_SRC = 14;
  localparam int IDX_W   = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_ENABLE   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_REQUEST  = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_VECTOR   = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_SETUP    = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_EXT_FLAG = 4'h4;

  // Field positions
  localparam int SETUP_AUTOVEC_BIT = 0;
  localparam int EXT_MAIN_BIT      = 6;

  // Vector encoding
  localparam logic [7:0] VEC_BASE  = 8'h80;
  localparam logic [7:0] VEC_RESET = 8'h80;

  // Program addresses seen by the CPU at interrupt entry
  localparam logic [15:0] ENTRY_ADDR    = 16'h0053;
  localparam logic [15:0] PAGE_ADDR     = 16'h0054;
  localparam logic [15:0] AUTOVEC_ADDR  = 16'h0055;
  localparam logic [7:0]  LONG_JUMP_OPCODE_OPCODE   = 8'h02;
  localparam int          SERVICE_CYCLES = 8;

  // Reset values
  localparam logic [NUM_SRC-1:0] ENABLE_RESET  = 14'h0000;
  localparam logic [NUM_SRC-1:0] REQUEST_RESET = 14'h0000;

  // Source bits, lowest bit is highest priority
  typedef struct packed {
    logic waveform_event_src;
    logic waveform_engine_done_src;
    logic ep8_full_flag_src;
    logic ep6_full_flag_src;
    logic ep4_full_flag_src;
    logic ep2_full_flag_src;
    logic ep8_empty_flag_src;
    logic ep6_empty_flag_src;
    logic ep4_empty_flag_src;
    logic ep2_empty_flag_src;
    logic ep8_programmable_flag_src;
    logic ep6_programmable_flag_src;
    logic ep4_programmable_flag_src;
    logic ep2_programmable_flag_src;
  } fpi_src_type;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } fpi_bus_type;

  // Program fetch from the CPU core
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  mem_data;
  } fpi_fetch_type;

endpackage

//--- hdl/fpi_vector_pick.sv
// Priority pick of the highest active source into a registered vector code
`timescale 1ns/1ps
module fpi_vector_pick (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      resetn,
  input  wire logic                      clk_en,
  // Active sources, bit 0 highest priority
  input  wire logic [fpi_pkg::NUM_SRC-1:0] active,
  // Vector code
  output logic      [7:0]                vector
);

  logic [fpi_pkg::NUM_SRC:0] seen;
  logic [fpi_pkg::IDX_W-1:0] idx_acc [0:fpi_pkg::NUM_SRC];

  assign seen[0]    = 1'b0;
  assign idx_acc[0] = 4'h0;

  // Lower index masks every later one
  for (genvar i = 0; i < fpi_pkg::NUM_SRC; i++) begin : g_pick
    assign seen[i+1]    = seen[i] | active[i];
    assign idx_acc[i+1] = (active[i] && !seen[i]) ? 4'(i) : idx_acc[i];
  end

  // Holds the last code when nothing is active, so firmware reads stay stable
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      vector <= fpi_pkg::VEC_RESET;
    end else if (clk_en && |active) begin
      vector <= fpi_pkg::VEC_BASE | {2'b00, idx_acc[fpi_pkg::NUM_SRC], 2'b00};
    end
  end

endmodule

//--- tb/fpi_cpu_model.sv
// Behavioural CPU core and firmware taking the shared interrupt entry
`timescale 1ns/1ps
module fpi_cpu_model (
  // Clock
  input  wire logic             sys_clk,
  // Main request from the block
  input  wire logic             irq,
  // Program fetch path
  output fpi_pkg::fpi_fetch_type fetch,
  input  wire logic [7:0]       fetch_data
);
  initial fetch = '{valid:1'b0, addr:16'hffff, mem_data:8'hff};

  // One byte fetch; released lines carry inverted values, not stale ones
  task automatic get(input logic [15:0] ad, input logic [7:0] m, output logic [7:0] d);
    @(posedge sys_clk) fetch <= '{valid:1'b1, addr:ad, mem_data:m};
    @(posedge sys_clk) fetch <= '{valid:1'b0, addr:~ad, mem_data:~m};
    #1;
    d = fetch_data;
  endtask

  // Entry: opcode, preloaded page, then the table low byte
  task automatic take_irq(input logic [7:0] page, output logic [7:0] op,
                          output logic [15:0] target);
    logic [7:0] hi;
    logic [7:0] lo;
    int         n;
    n = 0;
    while (irq !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    get(fpi_pkg::ENTRY_ADDR, fpi_pkg::LONG_JUMP_OPCODE_OPCODE, op);
    get(fpi_pkg::PAGE_ADDR, page, hi);
    get(fpi_pkg::AUTOVEC_ADDR, fpi_pkg::VEC_BASE, lo);
    target = {hi, lo};
  endtask
endmodule

//--- tb/fpi_irq_autovector_tb.sv
// Self-checking bench for the shared FIFO and waveform interrupt block
`timescale 1ns/1ps
module fpi_irq_autovector_tb;
  localparam logic [3:0] EN = fpi_pkg::OFS_ENABLE;
  localparam logic [3:0] RQ = fpi_pkg::OFS_REQUEST;
  localparam logic [3:0] VC = fpi_pkg::OFS_VECTOR;
  localparam logic [3:0] SU = fpi_pkg::OFS_SETUP;
  localparam logic [3:0] EX = fpi_pkg::OFS_EXT_FLAG;
  // Design ports
  logic                   sys_clk   = 1'b0;
  logic                   resetn    = 1'b0;
  logic                   clk_en    = 1'b1;
  fpi_pkg::fpi_bus_type   bus       = '0;
  fpi_pkg::fpi_src_type   src_event = '0;
  fpi_pkg::fpi_fetch_type fetch;
  logic [15:0]            rd_data;
  logic [7:0]             fetch_data;
  logic                   irq;
  logic                   irq_pending;
  logic [7:0]             vec_out;
  // Bookkeeping
  int                     failures = 0;
  int                     n_tests  = 0;
  int                     cycles   = 0;
  int                     a;
  int                     b;
  logic                   rd_seen  = 1'b0;
  logic [31:0]            seed     = 32'h1dd1;
  logic [15:0]            exp_q[$];
  logic [15:0]            target;
  logic [7:0]             opcode;
  logic [7:0]             page;

  always #5 sys_clk = ~sys_clk;

  fpi_irq_autovector fpi_irq_autovector_inst (.sys_clk(sys_clk), .resetn(resetn),
    .clk_en(clk_en), .bus(bus), .rd_data(rd_data), .src_event(src_event), .fetch(fetch),
    .fetch_data(fetch_data), .fifo_port_shared_irq(irq), .irq_pending(irq_pending),
    .fifo_irq_vector_code(vec_out));
  fpi_cpu_model fpi_cpu_model_inst (.sys_clk(sys_clk), .irq(irq), .fetch(fetch),
    .fetch_data(fetch_data));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Code of source i: base plus four per step
  function automatic logic [15:0] vc(input int i);
    return {8'h00, fpi_pkg::VEC_BASE} + 16'(4 * i);
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Bus cycles; a released bus shows inverted lines
  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge sys_clk) bus <= '{addr:ad, wdata:d, wr:1'b1, rd:1'b0};
    @(posedge sys_clk) bus <= '{addr:~ad, wdata:~d, wr:1'b0, rd:1'b0};
  endtask

  task automatic rd(input logic [3:0] ad, input logic [15:0] e);
    @(posedge sys_clk) bus <= '{addr:ad, wdata:16'h0000, wr:1'b0, rd:1'b1};
    exp_q.push_back(e);
    @(posedge sys_clk) bus <= '{addr:~ad, wdata:16'hffff, wr:1'b0, rd:1'b0};
  endtask

  task automatic pulse(input logic [13:0] m);
    @(posedge sys_clk) src_event <= m;
    @(posedge sys_clk) src_event <= '0;
    #1;
  endtask

  // Read answers matched against the oldest note; hang guard
  always @(posedge sys_clk) begin
    if (rd_seen) chk(rd_data, exp_q.pop_front());
    rd_seen <= bus.rd;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    // Reset values and an unmapped offset
    rd(EN, 16'h0000);
    rd(RQ, 16'h0000);
    rd(VC, 16'h0080);
    rd(SU, 16'h0000);
    rd(EX, 16'h0000);
    rd(4'hf, 16'h0000);
    wr(EN, 16'h3fff);
    rd(EN, 16'h3fff);
    // Each source alone, cleared in service order
    for (int i = 0; i < fpi_pkg::NUM_SRC; i++) begin
      pulse(14'(1) << i);
      chk(16'(irq_pending), 16'h0001);
      rd(VC, vc(i));
      chk({8'h00, vec_out}, vc(i));
      rd(RQ, 16'(1) << i);
      rd(EX, 16'h0040);
      chk(16'(irq), 16'h0001);
      wr(RQ, 16'h0000);
      rd(RQ, 16'(1) << i);
      wr(EX, 16'h0000);
      wr(RQ, 16'(1) << i);
      rd(RQ, 16'h0000);
      rd(EX, 16'h0000);
    end
    // Two sources at once; the lower one leaves the other pending
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      a = int'(seed % 13);
      b = a + 1 + int'((seed >> 8) % (13 - a));
      pulse((14'(1) << a) | (14'(1) << b));
      rd(VC, vc(a));
      wr(EX, 16'h0000);
      wr(RQ, 16'(1) << a);
      rd(EX, 16'h0040);
      rd(VC, vc(b));
      chk({8'h00, vec_out}, vc(b));
      wr(EX, 16'h0000);
      wr(RQ, 16'(1) << b);
    end
    // Frozen clock enable: an event in a frozen cycle is not taken
    clk_en <= 1'b0;
    pulse(14'(1) << b);
    chk(16'(irq_pending), 16'h0000);
    clk_en <= 1'b1;
    rd(RQ, 16'h0000);
    // Masked source: request set, nothing raised until enabled
    wr(EN, 16'h3fff & ~(16'(1) << b));
    pulse(14'(1) << b);
    chk(16'(irq_pending), 16'h0000);
    wr(EX, 16'h0040);
    rd(EX, 16'h0000);
    rd(RQ, 16'(1) << b);
    wr(EN, 16'h3fff);
    #1;
    chk(16'(irq_pending), 16'h0001);
    rd(EX, 16'h0040);
    wr(EX, 16'h0000);
    wr(RQ, 16'(1) << b);
    // Entry fetch with substitution on, then off
    wr(SU, 16'h0001);
    rd(SU, 16'h0001);
    page = seed[15:8];
    pulse(14'(1) << a);
    fpi_cpu_model_inst.take_irq(page, opcode, target);
    chk({8'h00, opcode}, {8'h00, fpi_pkg::LONG_JUMP_OPCODE_OPCODE});
    chk(target, {page, fpi_pkg::VEC_BASE + 8'(4 * a)});
    wr(SU, 16'h0000);
    fpi_cpu_model_inst.take_irq(page, opcode, target);
    chk(target, {page, fpi_pkg::VEC_BASE});
    repeat (4) @(posedge sys_clk);
    final_report();
  end
endmodule
